// ---- core/scid_decoder.v ----
// Purpose: Command input decoder: PWM, frequency and move-to-sensor modes
// Assumes: Enable and both command inputs are asynchronous pins
// Notes:   Velocity is signed, positive means clockwise
`default_nettype none
`include "scid_defs.vh"

module scid_decoder #(
    parameter CNT_W = 24,
    parameter VEL_W = 16,
    parameter SILENCE_CYC = `SCID_SILENCE_CYC,
    parameter RAMP_DIV = `SCID_RAMP_DIV
) (
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire enablePin,
    input wire inputA,
    input wire inputB,
    output reg energized,
    output reg signed [VEL_W:0] velocity,
    output reg velocityCw
);
    localparam DW = 40;
    localparam [1:0] C_IDLE = 2'h0;
    localparam [1:0] C_DIV1 = 2'h1;
    localparam [1:0] C_DIV2 = 2'h2;
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_CW = 2'h1;
    localparam [1:0] S_CCW = 2'h2;
    localparam [1:0] D_NONE = 2'h0;
    localparam [1:0] D_CW = 2'h1;
    localparam [1:0] D_CCW = 2'h2;
    localparam [CNT_W-1:0] SILENCE = SILENCE_CYC[CNT_W-1:0];
    localparam [15:0] RAMP_LAST = RAMP_DIV[15:0] - 16'h1;
    localparam [31:0] CLK_HZ32 = `SCID_CLK_HZ;
    localparam [DW-1:0] CLK_HZ = {{(DW-32){1'b0}}, CLK_HZ32};

    // Byte-lane merge for register writes
    function [31:0] laneMerge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] sel;
        integer i;
        begin
            laneMerge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    laneMerge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg [2:0] sync1;
    reg [2:0] sync2;
    reg [2:0] sync3;
    wire enSync = sync2[0];
    wire dirSync = sync2[1];
    wire velSync = sync2[2];
    wire velEdge = sync2[2] ^ sync3[2];
    wire velRise = sync2[2] & ~sync3[2];
    reg [1:0] inSync1;
    reg [1:0] inSync2;
    reg [1:0] inSync3;
    wire reqCw = inSync2[0];
    wire reqCcw = inSync2[1];
    wire reqChange = |(inSync2 ^ inSync3);

    always @(posedge clk) begin
        if (rst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            inSync1 <= 2'h0;
            inSync2 <= 2'h0;
            inSync3 <= 2'h0;
        end else begin
            sync1 <= {inputB, inputA, enablePin};
            sync2 <= sync1;
            sync3 <= sync2;
            inSync1 <= {inputB, inputA};
            inSync2 <= inSync1;
            inSync3 <= inSync2;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [1:0] mode;
    reg [VEL_W-1:0] maxVel;
    reg [VEL_W-1:0] accel;
    reg [19:0] fMin;
    reg [19:0] fMax;
    reg [VEL_W-1:0] cmdMag;
    reg inputOff;
    reg [1:0] sState;
    wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wbWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    reg [31:0] rdData;
    wire [31:0] wrMerged = laneMerge(rdData, wb_dat_i, wb_sel_i);

    always @* begin
        case (wb_adr_i)
            `SCID_OFF_CTRL: rdData = {30'h0, mode};
            `SCID_OFF_MAXVEL: rdData = {{(32-VEL_W){1'b0}}, maxVel};
            `SCID_OFF_ACCEL: rdData = {{(32-VEL_W){1'b0}}, accel};
            `SCID_OFF_FMIN: rdData = {12'h0, fMin};
            `SCID_OFF_FMAX: rdData = {12'h0, fMax};
            `SCID_OFF_STATUS: rdData = {28'h0, sState != S_IDLE, velocityCw, inputOff, energized};
            `SCID_OFF_VEL: rdData = {{(31-VEL_W){1'b0}}, velocity};
            `SCID_OFF_CMD: rdData = {{(32-VEL_W){1'b0}}, cmdMag};
            default: rdData = 32'h0;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            mode <= `SCID_RST_MODE;
            maxVel <= `SCID_RST_MAXVEL;
            accel <= `SCID_RST_ACCEL;
            fMin <= `SCID_RST_FMIN;
            fMax <= `SCID_RST_FMAX;
        end else begin
            wb_ack_o <= wbReq;
            if (wbReq) begin
                wb_dat_o <= wb_we_i ? 32'h0 : rdData;
            end
            if (wbWr) begin
                case (wb_adr_i)
                    `SCID_OFF_CTRL: mode <= wrMerged[1:0];
                    `SCID_OFF_MAXVEL: maxVel <= wrMerged[VEL_W-1:0];
                    `SCID_OFF_ACCEL: accel <= wrMerged[VEL_W-1:0];
                    `SCID_OFF_FMIN: fMin <= wrMerged[19:0];
                    `SCID_OFF_FMAX: fMax <= wrMerged[19:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Edge timing measurement
    // ----------------------------------------
    reg [CNT_W-1:0] periodCnt;
    reg [CNT_W-1:0] highCnt;
    reg [CNT_W-1:0] silentCnt;
    reg haveRise;
    wire [CNT_W-1:0] periodNow = periodCnt + {{(CNT_W-1){1'b0}}, 1'b1};

    always @(posedge clk) begin
        if (rst || !enSync) begin
            periodCnt <= {CNT_W{1'b0}};
            highCnt <= {CNT_W{1'b0}};
            silentCnt <= {CNT_W{1'b0}};
            haveRise <= 1'b0;
            inputOff <= 1'b1;
        end else begin
            // Cycle counts between edges
            if (velRise) begin
                periodCnt <= {CNT_W{1'b0}};
                highCnt <= {{(CNT_W-1){1'b0}}, 1'b1};
                haveRise <= 1'b1;
            end else begin
                if (periodCnt != SILENCE) periodCnt <= periodNow;
                if (velSync && highCnt != SILENCE) highCnt <= highCnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            // Silence or static level turns input off
            if (velEdge) begin
                silentCnt <= {CNT_W{1'b0}};
            end else if (silentCnt != SILENCE) begin
                silentCnt <= silentCnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            if (velEdge && haveRise) begin
                inputOff <= 1'b0;
            end else if (silentCnt == SILENCE - {{(CNT_W-1){1'b0}}, 1'b1}) begin
                inputOff <= 1'b1;
                haveRise <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Speed computation
    // ----------------------------------------
    reg [1:0] cState;
    reg divStart;
    reg [DW-1:0] divNum;
    reg [DW-1:0] divDen;
    wire divBusy;
    wire divDone;
    wire [DW-1:0] divQuot;
    wire [DW-1:0] maxVelExt = {{(DW-VEL_W){1'b0}}, maxVel};

    scid_divider #(
        .W(DW)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .start(divStart),
        .num(divNum),
        .den(divDen),
        .busy(divBusy),
        .done(divDone),
        .quot(divQuot)
    );

    always @(posedge clk) begin
        if (rst || !enSync) begin
            cState <= C_IDLE;
            divStart <= 1'b0;
            divNum <= {DW{1'b0}};
            divDen <= {DW{1'b0}};
            cmdMag <= {VEL_W{1'b0}};
        end else begin
            divStart <= 1'b0;
            case (cState)
                C_IDLE: begin
                    if (velRise && haveRise && !divBusy) begin
                        divDen <= {{(DW-CNT_W){1'b0}}, periodNow};
                        divStart <= 1'b1;
                        if (mode == `SCID_MODE_FREQ) begin
                            divNum <= CLK_HZ;
                            cState <= C_DIV1;
                        end else if (mode == `SCID_MODE_PWM) begin
                            divNum <= {{(DW-CNT_W){1'b0}}, highCnt} * maxVelExt;
                            cState <= C_DIV2;
                        end else begin
                            divStart <= 1'b0;
                        end
                    end
                end
                C_DIV1: begin
                    if (divDone) begin
                        cState <= C_IDLE;
                        if (divQuot <= {20'h0, fMin} || fMax <= fMin) begin
                            cmdMag <= {VEL_W{1'b0}};
                        end else if (divQuot >= {20'h0, fMax}) begin
                            cmdMag <= maxVel;
                        end else begin
                            divNum <= {20'h0, divQuot[19:0] - fMin} * maxVelExt;
                            divDen <= {20'h0, fMax - fMin};
                            divStart <= 1'b1;
                            cState <= C_DIV2;
                        end
                    end
                end
                C_DIV2: begin
                    if (divDone) begin
                        cState <= C_IDLE;
                        cmdMag <= (divQuot > maxVelExt) ? maxVel : divQuot[VEL_W-1:0];
                    end
                end
                default: cState <= C_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Move to sensor
    // ----------------------------------------
    reg [1:0] lastDir;

    always @(posedge clk) begin
        if (rst || !enSync || mode != `SCID_MODE_SENSOR) begin
            sState <= S_IDLE;
            lastDir <= D_NONE;
        end else begin
            case (sState)
                S_IDLE: begin
                    if (reqCw && !reqCcw && lastDir != D_CW) begin
                        sState <= S_CW;
                        lastDir <= D_CW;
                    end else if (reqCcw && !reqCw && lastDir != D_CCW) begin
                        sState <= S_CCW;
                        lastDir <= D_CCW;
                    end
                end
                S_CW, S_CCW: begin
                    if (reqChange) sState <= S_IDLE;
                end
                default: sState <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Target and acceleration ramp
    // ----------------------------------------
    reg signed [VEL_W:0] target;
    reg [15:0] rampCnt;
    wire signed [VEL_W+1:0] velWide = {velocity[VEL_W], velocity};
    wire signed [VEL_W+1:0] tgtWide = {target[VEL_W], target};
    wire signed [VEL_W+1:0] accWide = {2'b00, accel};
    wire signed [VEL_W+1:0] upStep = velWide + accWide;
    wire signed [VEL_W+1:0] dnStep = velWide - accWide;
    wire [VEL_W:0] magPos = {1'b0, cmdMag};
    wire [VEL_W:0] maxPos = {1'b0, maxVel};

    always @* begin
        if (mode == `SCID_MODE_SENSOR) begin
            case (sState)
                S_CW: target = maxPos;
                S_CCW: target = -maxPos;
                default: target = {(VEL_W+1){1'b0}};
            endcase
        end else if (inputOff) begin
            target = {(VEL_W+1){1'b0}};
        end else begin
            target = dirSync ? magPos : -magPos;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            energized <= 1'b0;
            velocity <= {(VEL_W+1){1'b0}};
            velocityCw <= 1'b0;
            rampCnt <= 16'h0;
        end else begin
            energized <= enSync;
            rampCnt <= (rampCnt == RAMP_LAST) ? 16'h0 : rampCnt + 16'h1;
            if (!enSync) begin
                velocity <= {(VEL_W+1){1'b0}};
            end else if (rampCnt == RAMP_LAST) begin
                if (velWide < tgtWide) begin
                    velocity <= (upStep > tgtWide) ? target : upStep[VEL_W:0];
                end else if (velWide > tgtWide) begin
                    velocity <= (dnStep < tgtWide) ? target : dnStep[VEL_W:0];
                end
            end
            velocityCw <= !velocity[VEL_W] && velocity != {(VEL_W+1){1'b0}};
        end
    end
endmodule

`default_nettype wire

// ---- core/scid_defs.vh ----
// Purpose: Shared constants for the servo command input decoder
// Assumes: 200 MHz core clock, classic Wishbone register access
// Notes:   Definitions only
//
// What this block does
// - Unipolar PWM: speed proportional to duty cycle
// - Direction input high clockwise, low counter-clockwise
// - Velocity changes ramp at configured acceleration
// - No PWM edges for 50 ms means off
// - Static low or high PWM means zero
// - Enable high energizes, low requests disable
// - Disable completes within 10 ms
// - Frequency mode scales speed between min and max
// - Pulse train silent 50 ms commands zero
// - Sensor mode: first input clockwise, second counter-clockwise
// - Dropped move input decelerates then holds position
// - No two consecutive moves in same direction
// - Input change during motion cancels, stops, holds
// - After cancel accept only opposite direction request
`ifndef SCID_DEFS_VH
`define SCID_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCID_CLK_HZ 200000000
`define SCID_SILENCE_MS 50
`define SCID_SILENCE_CYC (`SCID_SILENCE_MS * (`SCID_CLK_HZ / 1000))
`define SCID_DISABLE_MS 10
`define SCID_RAMP_DIV 200

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SCID_OFF_CTRL 8'h00
`define SCID_OFF_MAXVEL 8'h04
`define SCID_OFF_ACCEL 8'h08
`define SCID_OFF_FMIN 8'h0c
`define SCID_OFF_FMAX 8'h10
`define SCID_OFF_STATUS 8'h14
`define SCID_OFF_VEL 8'h18
`define SCID_OFF_CMD 8'h1c

// ----------------------------------------
// Fields
// ----------------------------------------
`define SCID_MODE_PWM 2'h0
`define SCID_MODE_FREQ 2'h1
`define SCID_MODE_SENSOR 2'h2
`define SCID_ST_ENERGIZED 0
`define SCID_ST_INPUT_OFF 1
`define SCID_ST_DIR_CW 2
`define SCID_ST_MOVING 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCID_RST_MODE 2'h0
`define SCID_RST_MAXVEL 16'h1000
`define SCID_RST_ACCEL 16'h0010
`define SCID_RST_FMIN 20'h00000
`define SCID_RST_FMAX 20'haae60

`endif

// ---- core/scid_divider.v ----
// Purpose: Unsigned restoring divider, one quotient bit per clock
// Assumes: den nonzero; start only while not busy
// Notes:   Quotient held in a register until the next start
`default_nettype none

module scid_divider #(
    parameter W = 40
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire [W-1:0] num,
    input wire [W-1:0] den,
    output reg busy,
    output reg done,
    output reg [W-1:0] quot
);
    localparam [6:0] STEPS = W;

    reg [W:0] rem;
    reg [6:0] cnt;
    wire [W:0] shifted = {rem[W-1:0], quot[W-1]};
    wire [W:0] denExt = {1'b0, den};
    wire fits = shifted >= denExt;

    // ----------------------------------------
    // Shift and subtract
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rem <= {(W+1){1'b0}};
            quot <= {W{1'b0}};
            cnt <= 7'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem <= {(W+1){1'b0}};
                quot <= num;
                cnt <= STEPS;
                busy <= 1'b1;
            end else if (busy) begin
                rem <= fits ? shifted - denExt : shifted;
                quot <= {quot[W-2:0], fits};
                cnt <= cnt - 7'h01;
                if (cnt == 7'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ---- testbench/scid_checker.sv ----
// Purpose: Port assertions for the command input decoder
// Assumes: Bus writes use all four byte lanes
// Notes:   Bound to every decoder instance
`default_nettype none

module scid_checker #(
    parameter VEL_W = 16,
    parameter SILENCE_CYC = 10000000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic enablePin,
    input wire logic inputA,
    input wire logic inputB,
    input wire logic energized,
    input wire logic signed [VEL_W:0] velocity,
    input wire logic velocityCw
);
    // --------
    // Shadow state
    // --------
    logic [1:0] mode;
    logic [15:0] accel;
    logic [15:0] maxVel;
    logic signed [VEL_W:0] prevVel = '0;
    logic [7:0] aLow = 8'h00, aHigh = 8'h00, bLow = 8'h00;
    logic [31:0] bStable = 32'h0;
    logic prevB = 1'b0;
    wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire signed [VEL_W+1:0] step = velocity - prevVel;
    wire [VEL_W+1:0] absStep = step[VEL_W+1] ? -step : step;
    wire [VEL_W:0] absVel = velocity[VEL_W] ? -velocity : velocity;
    wire [VEL_W:0] absPrev = prevVel[VEL_W] ? -prevVel : prevVel;

    always @(posedge clk) begin
        if (rst) begin
            mode <= 2'h0;
            accel <= 16'h0010;
            maxVel <= 16'h1000;
        end else if (wr && wb_adr_i == 8'h00) begin
            mode <= wb_dat_i[1:0];
        end else if (wr && wb_adr_i == 8'h04) begin
            maxVel <= wb_dat_i[15:0];
        end else if (wr && wb_adr_i == 8'h08) begin
            accel <= wb_dat_i[15:0];
        end
        prevVel <= velocity;
        prevB <= inputB;
        aLow <= inputA ? 8'h00 : aLow + {7'h00, aLow != 8'hff};
        aHigh <= !inputA ? 8'h00 : aHigh + {7'h00, aHigh != 8'hff};
        bLow <= inputB ? 8'h00 : bLow + {7'h00, bLow != 8'hff};
        bStable <= (inputB != prevB) ? 32'h0 : bStable + 32'h1;
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ramp_step: assert property (energized && $past(energized) |-> absStep <= {2'h0, accel})
        else $error("velocity step exceeds acceleration");
    a_cw_cause: assert property (aLow == 8'hff |-> !(velocity > 0 && velocity > prevVel))
        else $error("clockwise speed-up without first input");
    a_ccw_dir: assert property (mode != 2'h2 && aHigh == 8'hff |-> !(velocity < 0 && velocity < prevVel))
        else $error("counter-clockwise speed-up with direction high");
    a_ccw_cause: assert property (mode == 2'h2 && bLow == 8'hff |-> !(velocity < 0 && velocity < prevVel))
        else $error("counter-clockwise move without second input");
    a_vel_bound: assert property (absVel <= {1'b0, maxVel})
        else $error("velocity beyond maximum");
    a_off_decay: assert property (mode != 2'h2 && bStable > SILENCE_CYC + 8 |-> absVel <= absPrev)
        else $error("speed grows with silent velocity input");
    a_disable_fast: assert property (!enablePin [*5] |=> !energized && velocity == 0)
        else $error("disable not complete");
    a_enable_on: assert property (enablePin [*8] |=> energized)
        else $error("motor not energized");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1c |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind scid_decoder scid_checker #(.VEL_W(VEL_W), .SILENCE_CYC(SILENCE_CYC)) chk (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .enablePin(enablePin), .inputA(inputA), .inputB(inputB),
    .energized(energized), .velocity(velocity), .velocityCw(velocityCw)
);
`default_nettype wire

// ---- testbench/scid_ctrl_model.sv ----
// Purpose: Controller driving the two command input pins, inputA and inputB
// Assumes: Period and high time given in clocks
// Notes:   High time equal to period gives a static high line
`default_nettype none

module scid_ctrl_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [15:0] period,
    input wire logic [15:0] highCyc,
    input wire logic dirCw,
    input wire logic sensor,
    input wire logic reqA,
    input wire logic reqB,
    output logic inputA = 1'b0,
    output logic inputB = 1'b0
);
    logic [15:0] cnt = 16'h0000;

    always @(posedge clk) begin
        cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
        if (sensor) begin
            inputA <= reqA;
            inputB <= reqB;
        end else begin
            inputA <= dirCw;
            inputB <= run && cnt < highCyc;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/servo_command_input_decoder_tb_top.sv ----
// Purpose: Self-checking bench for the command input decoder
// Assumes: Shortened silence and ramp counts
// Notes:   Scenarios run in sequence on one instance
`default_nettype none

module servo_command_input_decoder_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SILENCE = 20000;

    logic clk = 1'b0, rst = 1'b1, enPin = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0, wbDatR, rd;
    logic run = 1'b0, dirCw = 1'b1, sensor = 1'b0, reqA = 1'b0, reqB = 1'b0;
    logic [15:0] period = 16'h1f40, highCyc = 16'h0fa0;
    logic inA, inB, energized, velocityCw;
    logic signed [16:0] velocity;
    int numErrors = 0, nCompared = 0;

    always #2.5 clk = ~clk;

    scid_ctrl_model ctrl (.clk(clk), .run(run), .period(period), .highCyc(highCyc), .dirCw(dirCw),
        .sensor(sensor), .reqA(reqA), .reqB(reqB), .inputA(inA), .inputB(inB));

    scid_decoder #(.SILENCE_CYC(SILENCE), .RAMP_DIV(4)) dut (
        .clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatW), .wb_sel_i(4'hf), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .enablePin(enPin),
        .inputA(inA), .inputB(inB), .energized(energized), .velocity(velocity), .velocityCw(velocityCw)
    );

    // --------
    // Helpers
    // --------
    task automatic stopTest();
        if (numErrors == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] vel32();
        return {{15{velocity[16]}}, velocity};
    endfunction

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        chk("ack", 32'h1, {31'h0, wbAck});
        d = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    // --------
    // Scenarios
    // --------
    task automatic testRegs();
        logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
        logic [31:0] exp [6] = '{32'h0, 32'h1000, 32'h10, 32'h0, 32'haae60, 32'h0};
        for (int i = 0; i < 6; i++) begin
            wbXfer(1'b0, adr[i], 32'h0, rd);
            chk("reset value", exp[i], rd);
        end
        wbXfer(1'b1, 8'h18, 32'h1234, rd);
        wbXfer(1'b1, 8'h20, 32'h5678, rd);
        wbXfer(1'b0, 8'h18, 32'h0, rd);
        chk("read-only velocity", 32'h0, rd);
        wbXfer(1'b1, 8'h08, 32'h100, rd);
        wbXfer(1'b0, 8'h08, 32'h0, rd);
        chk("accel", 32'h100, rd);
    endtask

    task automatic testPwm();
        enPin <= 1'b1;
        run <= 1'b1;
        waitCyc(24200);
        wbXfer(1'b0, 8'h1c, 32'h0, rd);
        chk("duty command", 32'h800, rd);
        chk("velocity", 32'h800, vel32());
        chk("cw flag", 32'h1, {31'h0, velocityCw});
        chk("energized", 32'h1, {31'h0, energized});
        dirCw <= 1'b0;
        waitCyc(9000);
        chk("velocity", 32'hfffff800, vel32());
        chk("cw flag", 32'h0, {31'h0, velocityCw});
    endtask

    task automatic testSilence();
        highCyc <= 16'h1f40;
        waitCyc(SILENCE + 400);
        chk("velocity", 32'h0, vel32());
        wbXfer(1'b0, 8'h14, 32'h0, rd);
        chk("status", 32'h3, rd);
    endtask

    task automatic testFreq();
        wbXfer(1'b1, 8'h0c, 32'h61a80, rd);
        wbXfer(1'b1, 8'h10, 32'h927c0, rd);
        wbXfer(1'b1, 8'h00, 32'h1, rd);
        period <= 16'h0190;
        highCyc <= 16'h00c8;
        dirCw <= 1'b1;
        waitCyc(2000);
        wbXfer(1'b0, 8'h1c, 32'h0, rd);
        chk("rate command", 32'h800, rd);
        chk("velocity", 32'h800, vel32());
    endtask

    task automatic testDisable();
        enPin <= 1'b0;
        waitCyc(8);
        chk("energized", 32'h0, {31'h0, energized});
        chk("velocity", 32'h0, vel32());
        enPin <= 1'b1;
        waitCyc(10);
        chk("energized", 32'h1, {31'h0, energized});
    endtask

    task automatic testSensor();
        sensor <= 1'b1;
        wbXfer(1'b1, 8'h00, 32'h2, rd);
        waitCyc(200);
        reqA <= 1'b1;
        waitCyc(100);
        chk("cw flag", 32'h1, {31'h0, velocityCw});
        wbXfer(1'b0, 8'h14, 32'h0, rd);
        chk("status", 32'hf, rd);
        reqA <= 1'b0;
        waitCyc(200);
        chk("velocity", 32'h0, vel32());
        reqA <= 1'b1;
        waitCyc(200);
        chk("velocity", 32'h0, vel32());
        reqA <= 1'b0;
        waitCyc(10);
        reqB <= 1'b1;
        waitCyc(40);
        chk("ccw sign", 32'h1, {31'h0, velocity[16]});
        reqA <= 1'b1;
        waitCyc(200);
        chk("velocity", 32'h0, vel32());
        reqA <= 1'b0;
        reqB <= 1'b0;
        waitCyc(10);
        reqB <= 1'b1;
        waitCyc(200);
        chk("velocity", 32'h0, vel32());
        reqB <= 1'b0;
        waitCyc(10);
        reqA <= 1'b1;
        waitCyc(40);
        chk("cw flag", 32'h1, {31'h0, velocityCw});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        testRegs();
        testPwm();
        testSilence();
        testFreq();
        testDisable();
        testSensor();
        stopTest();
    end

    initial begin
        repeat (100000) @(posedge clk);
        chk("watchdog", 32'h0, 32'h1);
        stopTest();
    end
endmodule
`default_nettype wire
